// File: rtl/tssor_pkg.sv
/*
  Constants, field layouts and carrier types for the touch sense status
  and offset register slice. Assumes a 32-bit AHB-Lite host and
  word-spaced registers (byte address is four times the index).
*/
package tssor_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [31:0] IDX_DCLK = 32'h000a0910;
  localparam logic [31:0] IDX_STAT = 32'h000a0911;
  localparam logic [31:0] IDX_SSC  = 32'h000a0912;
  localparam logic [31:0] IDX_SO0  = 32'h000a0914;

  // ==========================================================
  // Field positions and widths
  localparam int DIV_LSB    = 8;
  localparam int DIV_W      = 4;
  localparam int OFS_LSB    = 0;
  localparam int OFS_W      = 10;
  localparam int CNT_LSB    = 10;
  localparam int CNT_W      = 6;
  localparam int STAT_W     = 8;

  // ==========================================================
  // Reset values and fixed codes
  localparam logic [7:0]  RST_DCLK     = 8'h00;
  localparam logic [3:0]  RST_DIV      = 4'h0;
  localparam logic [15:0] RST_SO       = 16'h0000;
  localparam logic [15:0] SAT_VALUE    = 16'hffff;
  localparam logic [1:0]  MODE_MUTUAL  = 2'h3;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic        HRESP_OKAY   = 1'b0;
  localparam logic [2:0]  STC_S0       = 3'h0;
  localparam logic [2:0]  STC_S1       = 3'h1;
  localparam logic [2:0]  STC_S2       = 3'h2;
  localparam logic [2:0]  STC_S3       = 3'h3;
  localparam logic [2:0]  STC_S4       = 3'h4;
  localparam logic [2:0]  STC_S5       = 3'h5;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] amount;
    logic [1:0] rsv_lo;
    logic [1:0] mode;
  } tssor_dclk_t;

  typedef struct packed {
    logic       phase;
    logic       ref_ovf;
    logic       sen_ovf;
    logic       xfer;
    logic       rsv;
    logic [2:0] stc;
  } tssor_status_t;
endpackage : tssor_pkg

// File: rtl/tssor_ovf_flag.sv
/*
  Sticky counter overflow flag with read-then-write-zero clear.
  Assumes read and write strobes come from the bus slave, one cycle each.
*/
`timescale 1ns/100ps
module tssor_ovf_flag (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic set,
  input  wire logic init,
  input  wire logic rd,
  input  wire logic wr,
  input  wire logic wbit,
  output logic      flag
);
  logic armed;

  // ==========================================================
  // Arm on a read that saw the flag high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else if (wr || init) begin
      armed <= 1'b0;
    end else if (rd && flag) begin
      armed <= 1'b1;
    end
  end

  // Set wins so an overflow in the clearing cycle is kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;  // [RULE_07] [RULE_08]
    end else if (init || (wr && !wbit && armed)) begin
      flag <= 1'b0;  // [RULE_10]
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_10]
    set |=> flag) else $error("overflow lost in clear cycle");
  blind_clr_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_10]
    (flag && !armed && !set && !init) |=> flag)
    else $error("flag cleared without prior read");
endmodule : tssor_ovf_flag

// File: rtl/tssor_status_seq.sv
/*
  Measurement status counter sequencer, states 0 to 5.
  Assumes the unit delivers one-cycle event pulses in step order.
*/
`timescale 1ns/100ps
module tssor_status_seq (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       init,
  input  wire logic       wr_req,
  input  wire logic       so1_write,
  input  wire logic       meas_begin,
  input  wire logic       meas_done,
  input  wire logic       rc_read,
  input  wire logic       last_chan,
  output logic [2:0]      stc
);
  import tssor_pkg::*;

  typedef enum logic [2:0] {IDLE, WAIT_WR, SETUP, ARMED, MEASURE, RESULT} tssor_st_t;
  tssor_st_t st;
  tssor_st_t next_st;
  logic      start_q;

  // ==========================================================
  // Next state; dropping start always returns to idle
  always_comb begin
    next_st = st;
    case (st)
      IDLE:    if (start && !start_q) next_st = WAIT_WR;
      WAIT_WR: if (wr_req) next_st = SETUP;
      SETUP:   if (so1_write) next_st = ARMED;  // [RULE_19]
      ARMED:   if (meas_begin) next_st = MEASURE;
      MEASURE: if (meas_done) next_st = RESULT;  // [RULE_09]
      RESULT:  if (rc_read) next_st = last_chan ? IDLE : WAIT_WR;
      default: next_st = IDLE;
    endcase
    if (init || !start) next_st = IDLE;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st      <= IDLE;
      start_q <= 1'b0;
    end else begin
      st      <= next_st;
      start_q <= start;
    end
  end

  // Status code registered from the next state, so the status
  // output of the slice comes straight from a flip-flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stc <= STC_S0;
    end else begin
      case (next_st)
        IDLE:    stc <= STC_S0;
        WAIT_WR: stc <= STC_S1;
        SETUP:   stc <= STC_S2;
        ARMED:   stc <= STC_S3;
        MEASURE: stc <= STC_S4;
        RESULT:  stc <= STC_S5;
        default: stc <= STC_S0;
      endcase
    end
  end  // [RULE_05]

  so1_step_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE_19]
    (st == SETUP && so1_write && start && !init) |=> stc == STC_S3)
    else $error("offset write did not reach status 3");
endmodule : tssor_status_seq

// File: rtl/tssor_regs.sv
/*
  Touch sense status and offset register slice: diffusion clock control,
  measurement status, spread spectrum divider and sensor offset/count,
  behind an AHB-Lite slave with zero wait states.
  Assumes the rest of the touch sense unit supplies start, init, mode and
  one-cycle event pulses on this clock, and that the host issues single
  word transfers separated by idle, as the bus master here does.
*/
// What this block does
// (RULE_01) Software sets diffusion mode to 00b
// (RULE_02) Software sets diffusion amount to 11b
// (RULE_03) Diffusion control written only while stopped
// (RULE_04) Reserved bits read zero, written zero
// (RULE_05) Three-bit status counter, codes 0 to 5
// (RULE_06) Transfer flag: set on done, cleared on read
// (RULE_07) Sensor overflow flag; sensor result reads FFFFh
// (RULE_08) Reference overflow flag; reference result reads FFFFh
// (RULE_09) Overflow neither stops measurement nor interrupts
// (RULE_10) Overflow cleared by zero after one read
// (RULE_11) Init clearing only while start is zero; here INIT clears whatever START is
// (RULE_12) Mutual full scan: phase shows first/second
// (RULE_13) Phase reads zero when stopped or other mode
// (RULE_14) Four-bit division field in bits 11:8
// (RULE_15) Software picks division from base clock
// (RULE_16) Ten-bit linear sensor current offset field
// (RULE_17) Pulse sequence repeats count plus one
// (RULE_18) Offset and count written after write request
// (RULE_19) Offset register one write moves to status 3
// (RULE_20) Sensor counter read before reference counter
// (RULE_21) Status read-only fields ignore bus writes
`timescale 1ns/100ps
module tssor_regs (
  input  wire logic                  CLK,
  input  wire logic                  RSTN,
  input  wire logic                  HSEL,
  input  wire logic [31:0]           HADDR,
  input  wire logic [1:0]            HTRANS,
  input  wire logic                  HWRITE,
  input  wire logic [2:0]            HSIZE,
  input  wire logic [31:0]           HWDATA,
  input  wire logic                  HREADY,
  output logic      [31:0]           HRDATA,
  output logic                       HREADYOUT,
  output logic                       HRESP,
  input  wire logic                  START,
  input  wire logic                  INIT,
  input  wire logic [1:0]            MODE,
  input  wire logic                  WR_REQ,
  input  wire logic                  SO1_WRITE,
  input  wire logic                  MEAS_BEGIN,
  input  wire logic                  MEAS_DONE,
  input  wire logic                  RC_READ,
  input  wire logic                  LAST_CHANNEL,
  input  wire logic                  SC_OVF,
  input  wire logic                  RC_OVF,
  input  wire logic [15:0]           SC_RAW,
  input  wire logic [15:0]           RC_RAW,
  output tssor_pkg::tssor_dclk_t     DCLK_CTRL,
  output logic      [3:0]            SS_DIV,
  output logic      [9:0]            SENSOR_OFFSET,
  output logic      [5:0]            MEAS_COUNT,
  output logic      [6:0]            REPEAT_TOTAL,
  output tssor_pkg::tssor_status_t   MEAS_STATUS,
  output logic      [15:0]           SC_RESULT,
  output logic      [15:0]           RC_RESULT
);
  import tssor_pkg::*;

  // ==========================================================
  // Declarations
  logic        addr_ok;
  logic [3:0]  asel;
  logic [3:0]  dsel;
  logic        dwrite;
  logic [31:0] next_rdata;
  logic [2:0]  stc;
  logic [1:0]  ovf;
  logic [1:0]  ovf_set;
  logic        stat_rd;
  logic        stat_wr;
  logic        xfer;
  logic        phase;
  logic        mutual;
  logic [15:0] so_reg;
  logic [3:0]  div_reg;
  tssor_dclk_t dclk_reg;

  // ==========================================================
  // Address decode, used in the address phase only
  function automatic logic [3:0] reg_decode(input logic [31:0] a);
    reg_decode = {a == {IDX_SO0[29:0], 2'b00},
                  a == {IDX_SSC[29:0], 2'b00},
                  a == {IDX_STAT[29:0], 2'b00},
                  a == {IDX_DCLK[29:0], 2'b00}};
  endfunction : reg_decode

  assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NSEQ);
  assign asel    = addr_ok ? reg_decode(HADDR) : 4'h0;
  assign stat_rd = asel[1] && !HWRITE;
  assign stat_wr = dwrite && dsel[1];
  assign mutual  = START && (MODE == MODE_MUTUAL);

  // ==========================================================
  // AHB-Lite slave: no wait states, always OKAY
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end
  end

  // Write address latched into the data phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dsel   <= 4'h0;
      dwrite <= 1'b0;
    end else begin
      dsel   <= asel;
      dwrite <= addr_ok && HWRITE;
    end
  end

  // Read data assembled in the address phase; reserved bits zero,
  // unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (asel)
      4'h1: next_rdata = {24'h000000, 2'b00, dclk_reg.amount, 2'b00, dclk_reg.mode};  // [RULE_04]
      4'h2: next_rdata = {24'h000000, MEAS_STATUS};
      4'h4: next_rdata = {16'h0000, 4'h0, div_reg, 8'h00};  // [RULE_04]
      4'h8: next_rdata = {16'h0000, so_reg};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Cycles without a read transfer hold the previous word stable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // ==========================================================
  // Diffusion clock control; mode and amount are stored as written,
  // the host is trusted to keep them at 00b and 11b while stopped
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dclk_reg <= RST_DCLK;
    end else if (dwrite && dsel[0]) begin
      dclk_reg.mode   <= HWDATA[1:0];  // [RULE_01]
      dclk_reg.amount <= HWDATA[5:4];  // [RULE_02]
    end
  end

  // Spread spectrum divider, only bits 11:8 are stored
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_reg <= RST_DIV;
    end else if (dwrite && dsel[2]) begin
      div_reg <= HWDATA[DIV_LSB +: DIV_W];  // [RULE_14]
    end
  end

  // Sensor offset and measurement count, one 16-bit word
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      so_reg <= RST_SO;
    end else if (dwrite && dsel[3]) begin
      so_reg <= HWDATA[15:0];  // [RULE_16] [RULE_17]
    end
  end

  // ==========================================================
  // Status counter sequencer
  tssor_status_seq u_seq (
    .clk        (CLK),
    .rstn       (RSTN),
    .start      (START),
    .init       (INIT),
    .wr_req     (WR_REQ),
    .so1_write  (SO1_WRITE),
    .meas_begin (MEAS_BEGIN),
    .meas_done  (MEAS_DONE),
    .rc_read    (RC_READ),
    .last_chan  (LAST_CHANNEL),
    .stc        (stc)
  );

  // ==========================================================
  // Overflow flags, sensor at bit 5 and reference at bit 6
  assign ovf_set = {RC_OVF, SC_OVF};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ovf
      tssor_ovf_flag u_flag (
        .clk  (CLK),
        .rstn (RSTN),
        .set  (ovf_set[gi]),
        .init (INIT),
        .rd   (stat_rd),
        .wr   (stat_wr),
        .wbit (HWDATA[5 + gi]),
        .flag (ovf[gi])
      );  // [RULE_10]
    end
  endgenerate

  // ==========================================================
  // Transfer flag; the completion event wins over a same-cycle read
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      xfer <= 1'b0;
    end else if (MEAS_DONE) begin
      xfer <= 1'b1;  // [RULE_06]
    end else if (RC_READ || INIT) begin
      xfer <= 1'b0;  // [RULE_06]
    end
  end

  // Mutual scan phase: toggles on each completed measurement so the
  // pair of measurements per channel reads 0 then 1
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase <= 1'b0;
    end else if (!mutual || INIT) begin
      phase <= 1'b0;  // [RULE_13]
    end else if (MEAS_DONE) begin
      phase <= !phase;  // [RULE_12]
    end
  end

  // ==========================================================
  // Results saturate while the overflow flag stands; measurement
  // carries on and no interrupt is raised here
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SC_RESULT <= 16'h0000;
      RC_RESULT <= 16'h0000;
    end else begin
      SC_RESULT <= (ovf[0] || SC_OVF) ? SAT_VALUE : SC_RAW;  // [RULE_07] [RULE_09]
      RC_RESULT <= (ovf[1] || RC_OVF) ? SAT_VALUE : RC_RAW;  // [RULE_08] [RULE_09]
    end
  end

  // Repeat count precomputed for the pulse sequencer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REPEAT_TOTAL <= 7'h01;
    end else begin
      REPEAT_TOTAL <= 7'({1'b0, next_count()} + 7'h01);  // [RULE_17]
    end
  end

  function automatic logic [5:0] next_count();
    next_count = (dwrite && dsel[3]) ? HWDATA[CNT_LSB +: CNT_W] : so_reg[CNT_LSB +: CNT_W];
  endfunction : next_count

  // ==========================================================
  // Outputs, each non-reserved bit a flip-flop; status writes only touch the overflow flags
  assign MEAS_STATUS   = '{phase: phase, ref_ovf: ovf[1],
                           sen_ovf: ovf[0],
                           xfer: xfer, rsv: 1'b0, stc: stc};  // [RULE_05] [RULE_21]
  assign DCLK_CTRL     = '{rsv_hi: 2'b00, amount: dclk_reg.amount,
                           rsv_lo: 2'b00, mode: dclk_reg.mode};
  assign SS_DIV        = div_reg;
  assign SENSOR_OFFSET = so_reg[OFS_LSB +: OFS_W];  // [RULE_16]
  assign MEAS_COUNT    = so_reg[CNT_LSB +: CNT_W];

  // ==========================================================
  // Checks
  dclk_rsv_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_04]
    (addr_ok && !HWRITE && asel[0]) |=> (HRDATA[31:6] == 26'h0)
      && (HRDATA[3:2] == 2'b00))
    else $error("diffusion reserved bits read nonzero");

  ssc_rsv_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_04] [RULE_14]
    (addr_ok && !HWRITE && asel[2]) |=> (HRDATA[7:0] == 8'h00)
      && (HRDATA[31:12] == 20'h0))
    else $error("divider reserved bits read nonzero");

  div_store_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_14]
    (dwrite && dsel[2]) |=> SS_DIV == $past(HWDATA[11:8]))
    else $error("division field not stored");

  xfer_set_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_06]
    MEAS_DONE |=> MEAS_STATUS.xfer)
    else $error("transfer flag not set");

  xfer_clr_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_06]
    (RC_READ && !MEAS_DONE) |=> !MEAS_STATUS.xfer)
    else $error("transfer flag not cleared");

  xfer_init_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_06]
    (INIT && !MEAS_DONE) |=> !MEAS_STATUS.xfer)
    else $error("init did not clear transfer flag");

  sc_sat_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_07]
    MEAS_STATUS.sen_ovf |=> SC_RESULT == 16'hffff)
    else $error("sensor result not saturated");

  rc_sat_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_08]
    MEAS_STATUS.ref_ovf |=> RC_RESULT == 16'hffff)
    else $error("reference result not saturated");

  ovf_runs_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_09]
    (stc == STC_S4 && (SC_OVF || RC_OVF) && START && !INIT && !MEAS_DONE) |=> stc == STC_S4)
    else $error("overflow stopped measurement");

  phase_flip_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_12]
    (mutual && MEAS_DONE && !INIT) |=> (phase != $past(phase)))
    else $error("phase did not advance");

  phase_idle_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_13]
    !mutual |=> !MEAS_STATUS.phase)
    else $error("phase not zero outside mutual scan");

  ovf_clear_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_10]
    (INIT && !SC_OVF) |=> !MEAS_STATUS.sen_ovf)
    else $error("init did not clear overflow");

  stat_ro_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_21]
    (stat_wr && !MEAS_DONE && !RC_READ && !INIT) |=> xfer == $past(xfer))
    else $error("transfer flag moved by bus write");

  stat_rsv_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_04]
    (addr_ok && !HWRITE && asel[1]) |=> (HRDATA[31:8] == 24'h0) && !HRDATA[3])
    else $error("status reserved bits read nonzero");

  repeat_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_17]
    REPEAT_TOTAL == {1'b0, MEAS_COUNT} + 7'h01)
    else $error("repeat total not count plus one");

  stc_range_a: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_05]
    stc <= STC_S5)
    else $error("status code out of range");
endmodule : tssor_regs

// File: tb/tssor_sense_model.sv
/*
  Sense side model: counters and measurement events of the unit.
  Assumes bench commands change just after a rising clock edge.
*/
`timescale 1ns/100ps
module tssor_sense_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic [7:0]  len,
  input  wire logic [3:0]  lag,
  input  wire logic        ovf_sc,
  input  wire logic        ovf_rc,
  output logic             meas_begin,
  output logic             meas_done,
  output logic             sc_ovf,
  output logic             rc_ovf,
  output logic      [15:0] sc_raw,
  output logic      [15:0] rc_raw
);
  logic [1:0] st;
  logic [7:0] cnt;

  // ==========================================================
  // Sequencer
  // Waits lag cycles, then counts len cycles; overflow never stops it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st         <= 2'h0;
      cnt        <= 8'h00;
      meas_begin <= 1'b0;
      meas_done  <= 1'b0;
      sc_ovf     <= 1'b0;
      rc_ovf     <= 1'b0;
      sc_raw     <= 16'h0000;
      rc_raw     <= 16'h0000;
    end else begin
      meas_begin <= 1'b0;
      meas_done  <= 1'b0;
      sc_ovf     <= 1'b0;
      rc_ovf     <= 1'b0;
      case (st)
        2'h0: if (go) begin
          st  <= 2'h1;
          cnt <= {4'h0, lag};
        end
        2'h1: if (cnt == 8'h00) begin
          st         <= 2'h2;
          cnt        <= len;
          meas_begin <= 1'b1;
          sc_raw     <= 16'h0000; // Counters clear as a measurement starts
          rc_raw     <= 16'h0000;
        end else begin
          cnt <= cnt - 8'h01;
        end
        2'h2: begin
          sc_raw <= sc_raw + 16'h0003;
          rc_raw <= rc_raw + 16'h0001;
          cnt    <= cnt - 8'h01;
          if (cnt == {1'b0, len[7:1]}) begin
            sc_ovf <= ovf_sc; // Mid-run overflow, counting goes on
            rc_ovf <= ovf_rc;
          end
          if (cnt == 8'h01) begin
            meas_done <= 1'b1;
            st        <= 2'h0;
          end
        end
        default: st <= 2'h0;
      endcase
    end
  end
endmodule : tssor_sense_model

// File: tb/tb_top.sv
/*
  Self-checking bench for the status and offset register slice.
  Assumes the zero-wait AHB-Lite slave and event pulses of the design.
*/
`timescale 1ns/100ps
module tb_top;
  import tssor_pkg::*;
  localparam logic [31:0] A_DCLK = {IDX_DCLK[29:0], 2'b00};
  localparam logic [31:0] A_STAT = {IDX_STAT[29:0], 2'b00};
  localparam logic [31:0] A_SSC  = {IDX_SSC[29:0], 2'b00};
  localparam logic [31:0] A_SO0  = {IDX_SO0[29:0], 2'b00};
  localparam logic [31:0] A_GAP  = A_SO0 + 32'h4;
  logic          clk, rstn, hsel, hwrite, hrdy, hresp, start, last, go, osc, orc;
  logic          mb, md, so, ro;
  logic [1:0]    htrans, mode;
  logic [3:0]    ev, lag, div;
  logic [7:0]    len;
  logic [5:0]    mcnt;
  logic [6:0]    rpt;
  logic [9:0]    ofs;
  logic [15:0]   scr, rcr, sc_res, rc_res;
  logic [31:0]   haddr, hwdata, hrdata, q;
  tssor_dclk_t   dclk;
  tssor_status_t st;
  int            failures, total_checks;

  tssor_regs dut_u (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .START(start), .INIT(ev[3]), .MODE(mode),
    .WR_REQ(ev[0]), .SO1_WRITE(ev[1]), .MEAS_BEGIN(mb), .MEAS_DONE(md), .RC_READ(ev[2]),
    .LAST_CHANNEL(last), .SC_OVF(so), .RC_OVF(ro), .SC_RAW(scr), .RC_RAW(rcr),
    .DCLK_CTRL(dclk), .SS_DIV(div), .SENSOR_OFFSET(ofs), .MEAS_COUNT(mcnt),
    .REPEAT_TOTAL(rpt), .MEAS_STATUS(st), .SC_RESULT(sc_res), .RC_RESULT(rc_res));
  tssor_sense_model sense_u (.clk(clk), .rstn(rstn), .go(go), .len(len), .lag(lag),
    .ovf_sc(osc), .ovf_rc(orc), .meas_begin(mb), .meas_done(md), .sc_ovf(so),
    .rc_ovf(ro), .sc_raw(scr), .rc_raw(rcr));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Bounded wait for hready, so a stuck slave ends as a mismatch
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 64);
    if (n >= 64) failures++;
  endtask : wait_rdy
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata; // Read data taken at the data-phase edge
    #1;
  endtask : bus
  task automatic pulse(input int k, input logic lc);
    @(posedge clk);
    ev[k] <= 1'b1;
    last  <= lc;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask : pulse
  task automatic wait_stc(input logic [2:0] exp);
    int n;
    n = 0;
    while (st.stc !== exp && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("status counter", {29'h0, exp}, {29'h0, st.stc});
  endtask : wait_stc
  task automatic measure(input logic [7:0] l, input logic s, input logic r, input logic [3:0] g);
    @(posedge clk);
    go  <= 1'b1;
    len <= l;
    osc <= s;
    orc <= r;
    lag <= g;
    @(posedge clk);
    go <= 1'b0;
    wait_stc(STC_S4);
    wait_stc(STC_S5);
  endtask : measure
  task automatic to_s3();
    @(posedge clk);
    start <= 1'b1;
    wait_stc(STC_S1);
    pulse(0, 1'b0);
    wait_stc(STC_S2);
    bus(A_SSC, 1'b1, 32'h0000_0300);
    bus(A_SO0, 1'b1, 32'h0000_1234);
    pulse(1, 1'b0);
    wait_stc(STC_S3);
  endtask : to_s3

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] a[5];
    a = '{A_DCLK, A_STAT, A_SSC, A_SO0, A_GAP};
    foreach (a[i]) begin
      bus(a[i], 1'b0, 32'h0);
      check("reset read", 32'h0, q);
    end
    check("response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    check("repeat total", 32'h1, {25'h0, rpt});
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    logic [31:0] v[3];
    bus(A_DCLK, 1'b1, 32'hffff_ffff);
    bus(A_DCLK, 1'b0, 32'h0);
    check("diffusion read", 32'h33, q);
    bus(A_DCLK, 1'b1, 32'h0000_0030);
    check("diffusion port", 32'h30, {24'h0, dclk});
    for (int c = 0; c < 16; c++) begin
      bus(A_SSC, 1'b1, 32'hffff_f0ff | (c << 8));
      bus(A_SSC, 1'b0, 32'h0);
      check("divider read", c << 8, q);
      check("divider port", c, {28'h0, div});
    end
    // Boundary values: 1022, all ones, count maximum and zero
    v = '{32'hffff_fffe, 32'h0000_03ff, 32'h0000_0401};
    foreach (v[i]) begin
      bus(A_SO0, 1'b1, v[i]);
      bus(A_SO0, 1'b0, 32'h0);
      check("offset read", {16'h0, v[i][15:0]}, q);
      check("offset port", {22'h0, v[i][9:0]}, {22'h0, ofs});
      check("count port", {26'h0, v[i][15:10]}, {26'h0, mcnt});
      check("repeat total", v[i][15:10] + 32'h1, {25'h0, rpt});
    end
    $display("test registers done");
  endtask : t_regs
  task automatic t_seq(input logic [1:0] m);
    logic ph;
    ph = (m == MODE_MUTUAL);
    @(posedge clk);
    mode <= m;
    to_s3();
    check("phase first", 32'h0, {31'h0, st.phase});
    measure(8'd10 + m, 1'b0, 1'b0, {m, 2'h0});
    check("transfer set", 32'h1, {31'h0, st.xfer});
    check("phase second", {31'h0, ph}, {31'h0, st.phase});
    bus(A_STAT, 1'b1, 32'h0000_009a);
    bus(A_STAT, 1'b0, 32'h0);
    check("status read", {24'h0, ph, 7'h15}, q);
    check("sensor result", 3 * (10 + m), {16'h0, sc_res});
    check("reference result", 10 + m, {16'h0, rc_res});
    pulse(2, m[0]);
    wait_stc(m[0] ? STC_S0 : STC_S1);
    check("transfer clear", 32'h0, {31'h0, st.xfer});
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1;
    wait_stc(STC_S0);
    check("phase stopped", 32'h0, {31'h0, st.phase});
    $display("test sequence mode %0d done", m);
  endtask : t_seq
  task automatic t_ovf();
    to_s3();
    measure(8'd20, 1'b1, 1'b1, 4'h0);
    check("sensor flag", 32'h1, {31'h0, st.sen_ovf});
    check("reference flag", 32'h1, {31'h0, st.ref_ovf});
    check("sensor saturated", 32'hffff, {16'h0, sc_res});
    check("reference saturated", 32'hffff, {16'h0, rc_res});
    @(posedge clk);
    start <= 1'b0;
    wait_stc(STC_S0);
    bus(A_STAT, 1'b1, 32'h0); // Zero write without a prior read must not clear
    bus(A_STAT, 1'b0, 32'h0);
    check("flags kept", 32'h70, q);
    bus(A_STAT, 1'b1, 32'h40);
    bus(A_STAT, 1'b0, 32'h0);
    check("sensor flag cleared", 32'h50, q);
    pulse(3, 1'b0);
    bus(A_STAT, 1'b0, 32'h0);
    check("init cleared", 32'h0, q);
    $display("test overflow done");
  endtask : t_ovf

  // ==========================================================
  // Verdict, clock, watchdog and main sequence
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run is a few hundred cycles; this margin only cuts hangs
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    {rstn, hsel, hwrite, start, last, go, osc, orc} = 8'h00;
    {htrans, mode, ev, lag, len} = 20'h0;
    {haddr, hwdata} = 64'h0;
    failures = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    for (int m = 0; m < 4; m++) t_seq(m[1:0]);
    t_ovf();
    summarize();
  end
endmodule : tb_top
